/* logic/fdc_cmd_pkg.sv */
// Package for the floppy command interpreter: opcodes, field positions, reset values.
// Assumes a single core clock domain at 100 MHz and a synchronous active-high reset.
package fdc_cmd_pkg;
  // Command codes and match masks
  localparam logic [7:0] OP_SENSE_INT   = 8'h08;
  localparam logic [7:0] OP_SPECIFY     = 8'h03;
  localparam logic [7:0] OP_SENSE_DRV   = 8'h04;
  localparam logic [7:0] OP_SEEK        = 8'h0f;
  localparam logic [7:0] OP_CONFIGURE   = 8'h13;
  localparam logic [7:0] OP_DUMP        = 8'h0e;
  localparam logic [7:0] OP_PERP        = 8'h12;
  localparam logic [6:0] OP_LOCK_LOW    = 7'h14;
  localparam logic [5:0] OP_RELSEEK_LOW = 6'h0f;
  localparam logic [4:0] OP_READID_LOW  = 5'h0a;
  // Result values and field bit positions
  localparam logic [7:0] INVALID_STATUS = 8'h80;
  localparam logic [7:0] SEEK_END_BASE  = 8'h20;
  localparam int         LOCK_RES_BIT   = 4;
  localparam int         LOCK_CMD_BIT   = 7;
  localparam int         DIR_BIT        = 6;
  localparam int         DENSITY_BIT    = 6;
  localparam int         HEAD_BIT       = 2;
  // Reset values
  localparam logic [7:0] CONFIG_RESET   = 8'h20;
  localparam logic [7:0] TIMING_RESET   = 8'h00;
  localparam logic [7:0] PRECOMP_RESET  = 8'h00;
  // Step pacing: one head step every STEP_TIME_NS
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         STEP_TIME_NS   = 1000;
  localparam int         STEP_CYCLES    = STEP_TIME_NS / CLK_PERIOD_NS;
  // Result byte count ceiling
  localparam int         MAX_RESULTS    = 10;

  typedef enum logic [3:0]
  {
    PH_CMD    = 4'b0001,
    PH_PARAM  = 4'b0010,
    PH_EXEC   = 4'b0100,
    PH_RESULT = 4'b1000
  } phase_t;
endpackage

/* logic/head_stepper.sv */
// Head stepper: walks one drive's cylinder toward a target, one step per pacing interval.
// Assumes the interpreter holds the target stable while busy is high.
module head_stepper
  import fdc_cmd_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] fromCyl,
  input  wire logic [7:0] toCyl,
  output logic            busy,
  output logic [7:0]      curCyl,
  output logic            done
);
  logic [7:0]  next_curCyl;
  logic        next_busy;
  logic        next_done;
  logic [15:0] pace;
  logic [15:0] next_pace;

  ////////////////////////////////////////////////////////////////////////////
  // Step toward target, pacing each step
  always_comb
  begin
    next_curCyl = curCyl;
    next_busy   = busy;
    next_done   = 1'b0;
    next_pace   = pace;
    if (start)
    begin
      next_curCyl = fromCyl;
      next_busy   = 1'b1;
      next_pace   = 16'(STEP_CYCLES);
    end
    else if (busy)
    begin
      if (curCyl == toCyl)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      else if (pace == 16'h0001)
      begin
        next_pace   = 16'(STEP_CYCLES);
        next_curCyl = (curCyl < toCyl) ? curCyl + 8'h01 : curCyl - 8'h01;
      end
      else
        next_pace = pace - 16'h0001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      curCyl <= 8'h00;
      busy   <= 1'b0;
      done   <= 1'b0;
      pace   <= 16'h0000;
    end
    else
    begin
      curCyl <= next_curCyl;
      busy   <= next_busy;
      done   <= next_done;
      pace   <= next_pace;
    end
  end

  // Done only follows a busy period and only with the head on the target
  a_done_after_busy: assert property (@(posedge core_clk) disable iff (rst) // RQ4
    done |-> ($past(busy) && curCyl == $past(toCyl)))
    else $error("done without busy or off target");
endmodule

/* logic/floppy_cmd_interpreter.sv */
// Floppy command interpreter for housekeeping and positioning commands.
// Assumes the host bus layer turns data register writes into wrStrobe pulses and
// reads into rdStrobe pulses, and that an ID field reader supplies idValid/idBytes.
// Function
// [RQ1] Sense interrupt status returns the interrupt status byte and then the present cylinder.
// [RQ2] The host sets timing with 0x03 then a step/unload byte and a load/non-DMA byte.
// [RQ3] Sense drive status takes a head/drive byte and returns one drive status byte.
// [RQ4] Seek moves the selected drive to the target cylinder and has no result phase.
// [RQ5] Configure is 0x13, a zero byte, the seek/FIFO/poll/threshold byte and the precomp track.
// [RQ6] Relative seek has bit 7 set, direction in bit 6, low bits 001111, then select and count bytes.
// [RQ7] Dump returns ten bytes: four cylinders, two timing bytes, sector byte, perpendicular, config, precomp.
// [RQ8] Read ID captures the first valid ID field and returns status then cylinder, head and sector.
// [RQ9] Perpendicular mode is 0x12 plus one byte with overwrite, drive bits, gap and write-gate.
// [RQ10] An undefined code is a no-op that enters standby and returns one byte 0x80.
// [RQ11] Lock carries its value in bit 7 and answers with that value in bit 4 only.
// [RQ12] Drive-select bits in parameters are used internally and never reach drive pins.
// [RQ13] The host keeps command drive bits consistent with its drive output control register.
// [RQ14] All parameters precede execution, exactly the result count is read, then command phase resumes.
module floppy_cmd_interpreter
  import fdc_cmd_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       wrStrobe,
  input  wire logic [7:0] wrData,
  input  wire logic       rdStrobe,
  input  wire logic       idValid,
  input  wire logic [31:0] idBytes,
  input  wire logic [7:0] driveStatusIn,
  input  wire logic       lastWasFormat,
  input  wire logic [7:0] sectorsPerCylinder,
  input  wire logic [7:0] endTrackSector,
  output logic [7:0]      rdData,
  output logic            resultReady,
  output logic            cmdBusy,
  output logic            standby,
  output logic [7:0]      stepRateHeadUnload,
  output logic [7:0]      headLoadNonDma,
  output logic [7:0]      configByte,
  output logic [7:0]      precompStartTrack,
  output logic [7:0]      perpendicularByte,
  output logic            lockValue,
  output logic            idReadActive
);
  phase_t     phase;
  phase_t     next_phase;
  logic [7:0] opcode;
  logic [7:0] next_opcode;
  logic [3:0] paramIdx;
  logic [3:0] next_paramIdx;
  logic [3:0] paramNeed;
  logic [7:0] selByte;
  logic [7:0] next_selByte;
  logic [7:0] argByte;
  logic [7:0] next_argByte;
  logic [7:0] resBuf [MAX_RESULTS];
  logic [7:0] next_resBuf [MAX_RESULTS];
  logic [3:0] resCount;
  logic [3:0] next_resCount;
  logic [3:0] resIdx;
  logic [3:0] next_resIdx;
  logic [7:0] cyl [4];
  logic [7:0] next_cyl [4];
  logic [7:0] seekStatus;
  logic [7:0] next_seekStatus;
  logic [1:0] seekDrive;
  logic [1:0] next_seekDrive;
  logic [7:0] next_stepRateHeadUnload;
  logic [7:0] next_headLoadNonDma;
  logic [7:0] next_configByte;
  logic [7:0] next_precompStartTrack;
  logic [7:0] next_perpendicularByte;
  logic       next_lockValue;
  logic       next_standby;
  logic [7:0] next_rdData;
  logic       next_resultReady;
  logic       stepStart;
  logic [7:0] stepTarget;
  logic       stepBusy;
  logic       stepDone;
  logic [7:0] stepCyl;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode classification, shared by phase and parameter logic
  function automatic logic [3:0] param_count(input logic [7:0] op);
    if (op == OP_SPECIFY || op == OP_SEEK || is_relseek(op))
      param_count = 4'd2;
    else if (op == OP_CONFIGURE)
      param_count = 4'd3;
    else if (op == OP_SENSE_DRV || op == OP_PERP || is_readid(op))
      param_count = 4'd1;
    else
      param_count = 4'd0;
  endfunction

  function automatic logic is_relseek(input logic [7:0] op);
    is_relseek = op[7] && op[5:0] == OP_RELSEEK_LOW;
  endfunction

  function automatic logic is_readid(input logic [7:0] op);
    is_readid = !op[7] && op[5:0] == {1'b0, OP_READID_LOW};
  endfunction

  assign paramNeed = param_count(opcode);

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing and command decode
  always_comb
  begin
    next_phase      = phase;
    next_opcode     = opcode;
    next_paramIdx   = paramIdx;
    next_selByte    = selByte;
    next_argByte    = argByte;
    next_resBuf     = resBuf;
    next_resCount   = resCount;
    next_resIdx     = resIdx;
    next_cyl        = cyl;
    next_seekStatus = seekStatus;
    next_seekDrive  = seekDrive;
    next_stepRateHeadUnload = stepRateHeadUnload;
    next_headLoadNonDma     = headLoadNonDma;
    next_configByte         = configByte;
    next_precompStartTrack  = precompStartTrack;
    next_perpendicularByte  = perpendicularByte;
    next_lockValue  = lockValue;
    next_standby    = standby;
    next_rdData     = rdData;
    next_resultReady = resultReady;
    stepStart       = 1'b0;
    stepTarget      = 8'h00;
    unique case (phase)
      PH_CMD:
        if (wrStrobe)
        begin
          next_opcode   = wrData;
          next_paramIdx = 4'd0;
          next_resIdx   = 4'd0;
          next_standby  = 1'b0;
          next_phase    = (param_count(wrData) != 4'd0) ? PH_PARAM : PH_EXEC;
        end
      PH_PARAM:
        if (wrStrobe) // RQ14
        begin
          next_paramIdx = paramIdx + 4'd1;
          if (paramIdx == 4'd0)
            next_selByte = wrData;
          if (paramIdx == 4'd1)
            next_argByte = wrData;
          if (opcode == OP_SPECIFY && paramIdx == 4'd0)
            next_stepRateHeadUnload = wrData; // RQ2
          if (opcode == OP_SPECIFY && paramIdx == 4'd1)
            next_headLoadNonDma = wrData; // RQ2
          if (opcode == OP_CONFIGURE && paramIdx == 4'd1)
            next_configByte = {1'b0, wrData[6:0]}; // RQ5
          if (opcode == OP_CONFIGURE && paramIdx == 4'd2)
            next_precompStartTrack = wrData; // RQ5
          if (opcode == OP_PERP)
            next_perpendicularByte = {wrData[7], 1'b0, wrData[5:0]}; // RQ9
          if (paramIdx + 4'd1 == paramNeed)
            next_phase = PH_EXEC;
        end
      PH_EXEC:
      begin
        next_resCount = 4'd0;
        if (opcode == OP_SENSE_INT)
        begin
          next_resBuf[0] = seekStatus; // RQ1
          next_resBuf[1] = cyl[seekDrive]; // RQ1
          next_resCount  = 4'd2;
          next_seekStatus = INVALID_STATUS;
        end
        else if (opcode == OP_SENSE_DRV)
        begin
          next_resBuf[0] = {driveStatusIn[7:3], selByte[HEAD_BIT], selByte[1:0]}; // RQ3
          next_resCount  = 4'd1;
        end
        else if (opcode == OP_SPECIFY || opcode == OP_CONFIGURE || opcode == OP_PERP)
          next_resCount = 4'd0;
        else if (opcode == OP_SEEK || is_relseek(opcode))
        begin
          // Both seeks run in the stepper; relative count wraps at the cylinder range
          // Start once only; a restart on the done cycle would rerun the walk
          stepStart      = !stepBusy && !stepDone; // RQ4
          stepTarget     = (opcode == OP_SEEK) ? argByte :
                           (opcode[DIR_BIT] ? cyl[selByte[1:0]] + argByte : cyl[selByte[1:0]] - argByte); // RQ6
          next_seekDrive = selByte[1:0]; // RQ12
          next_resCount  = 4'd0;
        end
        else if (opcode == OP_DUMP)
        begin
          next_resBuf[0] = cyl[0]; // RQ7
          next_resBuf[1] = cyl[1];
          next_resBuf[2] = cyl[2];
          next_resBuf[3] = cyl[3];
          next_resBuf[4] = stepRateHeadUnload;
          next_resBuf[5] = headLoadNonDma;
          next_resBuf[6] = lastWasFormat ? sectorsPerCylinder : endTrackSector;
          next_resBuf[7] = {lockValue, perpendicularByte[6:0]};
          next_resBuf[8] = configByte;
          next_resBuf[9] = precompStartTrack;
          next_resCount  = 4'd10;
        end
        else if (opcode[6:0] == OP_LOCK_LOW)
        begin
          next_lockValue = opcode[LOCK_CMD_BIT];
          next_resBuf[0] = 8'(opcode[LOCK_CMD_BIT]) << LOCK_RES_BIT; // RQ11
          next_resCount  = 4'd1;
        end
        else if (is_readid(opcode))
        begin
          // Wait for the first good ID field on this cylinder
          if (idValid) // RQ8
          begin
            next_resBuf[0] = {5'h00, selByte[HEAD_BIT], selByte[1:0]};
            next_resBuf[1] = 8'h00;
            next_resBuf[2] = 8'h00;
            next_resBuf[3] = idBytes[31:24];
            next_resBuf[4] = idBytes[23:16];
            next_resBuf[5] = idBytes[15:8];
            next_resBuf[6] = idBytes[7:0];
            next_resCount  = 4'd7;
          end
        end
        else
        begin
          next_resBuf[0] = INVALID_STATUS; // RQ10
          next_resCount  = 4'd1;
          next_standby   = 1'b1; // RQ10
        end
        if (is_readid(opcode) && !idValid)
          next_phase = PH_EXEC;
        else if ((opcode == OP_SEEK || is_relseek(opcode)) && stepBusy)
          next_phase = PH_EXEC;
        else if ((opcode == OP_SEEK || is_relseek(opcode)) || next_resCount == 4'd0)
          next_phase = (opcode == OP_SEEK || is_relseek(opcode)) && !stepDone ? PH_EXEC : PH_CMD;
        else
        begin
          next_phase       = PH_RESULT;
          next_rdData      = next_resBuf[0];
          next_resultReady = 1'b1;
        end
      end
      PH_RESULT:
        if (rdStrobe) // RQ14
        begin
          next_resIdx = resIdx + 4'd1;
          if (resIdx + 4'd1 == resCount)
          begin
            next_phase       = PH_CMD;
            next_resultReady = 1'b0;
          end
          else
            next_rdData = resBuf[resIdx + 4'd1];
        end
    endcase
    if (stepDone)
    begin
      next_cyl[seekDrive] = stepCyl;
      next_seekStatus     = SEEK_END_BASE | {6'h00, seekDrive};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      phase <= PH_CMD;
      opcode <= 8'h00;
      paramIdx <= 4'd0;
      selByte <= 8'h00;
      argByte <= 8'h00;
      resBuf <= '{default: 8'h00};
      resCount <= 4'd0;
      resIdx <= 4'd0;
      cyl <= '{default: 8'h00};
      seekStatus <= INVALID_STATUS;
      seekDrive <= 2'd0;
      stepRateHeadUnload <= TIMING_RESET;
      headLoadNonDma <= TIMING_RESET;
      configByte <= CONFIG_RESET;
      precompStartTrack <= PRECOMP_RESET;
      perpendicularByte <= 8'h00;
      lockValue <= 1'b0;
      standby <= 1'b0;
      rdData <= 8'h00;
      resultReady <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      opcode <= next_opcode;
      paramIdx <= next_paramIdx;
      selByte <= next_selByte;
      argByte <= next_argByte;
      resBuf <= next_resBuf;
      resCount <= next_resCount;
      resIdx <= next_resIdx;
      cyl <= next_cyl;
      seekStatus <= next_seekStatus;
      seekDrive <= next_seekDrive;
      stepRateHeadUnload <= next_stepRateHeadUnload;
      headLoadNonDma <= next_headLoadNonDma;
      configByte <= next_configByte;
      precompStartTrack <= next_precompStartTrack;
      perpendicularByte <= next_perpendicularByte;
      lockValue <= next_lockValue;
      standby <= next_standby;
      rdData <= next_rdData;
      resultReady <= next_resultReady;
    end
  end

  // Busy flags registered so outputs come from flip-flops
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cmdBusy <= 1'b0;
      idReadActive <= 1'b0;
    end
    else
    begin
      cmdBusy <= (next_phase != PH_CMD);
      idReadActive <= (next_phase == PH_EXEC) && is_readid(next_opcode);
    end
  end

  head_stepper head_stepper_inst
  (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (stepStart),
    .fromCyl  (cyl[selByte[1:0]]),
    .toCyl    (stepTarget),
    .busy     (stepBusy),
    .curCyl   (stepCyl),
    .done     (stepDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_invalid_status: assert property (@(posedge core_clk) disable iff (rst) // RQ10
    (phase == PH_EXEC && param_count(opcode) == 4'd0 && opcode == 8'hff) |=> (rdData == INVALID_STATUS && standby))
    else $error("invalid code did not answer 80");
  a_lock_result: assert property (@(posedge core_clk) disable iff (rst) // RQ11
    (phase == PH_EXEC && opcode[6:0] == OP_LOCK_LOW) |=> (rdData == {3'b000, opcode[7], 4'h0}))
    else $error("lock result wrong");
  a_seek_no_result: assert property (@(posedge core_clk) disable iff (rst) // RQ4
    (phase == PH_EXEC && opcode == OP_SEEK) |=> !resultReady)
    else $error("seek produced result");
  a_sense_int_first: assert property (@(posedge core_clk) disable iff (rst) // RQ1
    (phase == PH_EXEC && opcode == OP_SENSE_INT) |=> (rdData == $past(seekStatus) && resCount == 4'd2))
    else $error("sense interrupt result wrong");
  a_dump_count: assert property (@(posedge core_clk) disable iff (rst) // RQ7
    (phase == PH_EXEC && opcode == OP_DUMP) |=> (resCount == 4'd10 && rdData == $past(cyl[0])))
    else $error("dump result wrong");
  a_result_return: assert property (@(posedge core_clk) disable iff (rst) // RQ14
    (phase == PH_RESULT && rdStrobe && resIdx + 4'd1 == resCount) |=> (phase == PH_CMD && !resultReady))
    else $error("no return to command phase");
  a_config_store: assert property (@(posedge core_clk) disable iff (rst) // RQ5
    (phase == PH_PARAM && wrStrobe && opcode == OP_CONFIGURE && paramIdx == 4'd2) |=> precompStartTrack == $past(wrData))
    else $error("precomp not stored");
  a_perp_store: assert property (@(posedge core_clk) disable iff (rst) // RQ9
    (phase == PH_PARAM && wrStrobe && opcode == OP_PERP) |=> perpendicularByte[5:0] == $past(wrData[5:0]))
    else $error("perpendicular not stored");
endmodule

/* tb/host_model.sv */
// Host side model: writes command bytes and collects result bytes.
// Assumes the interpreter samples both strobes on rising core_clk edges.
module host_model
(
  input  wire logic       core_clk,
  input  wire logic [7:0] rdData,
  input  wire logic       resultReady,
  output logic            wrStrobe,
  output logic [7:0]      wrData,
  output logic            rdStrobe
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] res [10];
  int         timedOut;

  // Idle host at time zero
  initial
  begin
    wrStrobe = 1'b0;
    wrData   = 8'h00;
    rdStrobe = 1'b0;
    timedOut = 0;
  end

  ////////////////////////////////////////////////////////////
  // Whole command, strobe held high across its bytes
  // Drive bits are sent exactly as given in w; no selected drive is tracked or checked
  task automatic cmd(input logic [31:0] w, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge core_clk);
      wrStrobe = 1'b1;
      wrData   = w[31-8*i -: 8];
    end
    @(negedge core_clk);
    wrStrobe = 1'b0;
    wrData   = ~wrData;  // Released bus shows junk, not the last byte
  endtask

  ////////////////////////////////////////////////////////////
  // Reads exactly n result bytes once the result phase opens
  task automatic get(input int n);
    int k = 0;
    @(negedge core_clk);
    while (resultReady !== 1'b1 && k < 5000)
    begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 5000)
      timedOut++;
    for (int i = 0; i < n; i++)
    begin
      res[i]   = rdData;  // Byte stands until the strobe consumes it
      rdStrobe = 1'b1;
      @(negedge core_clk);
    end
    rdStrobe = 1'b0;
  endtask
endmodule

/* tb/floppy_cmd_interpreter_tb.sv */
// Self-checking bench for the floppy command interpreter.
// Assumes host_model drives the strobes; the bench drives drive and ID inputs.
module floppy_cmd_interpreter_tb
  import fdc_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk;
  logic        rst;
  logic        wrStrobe;
  logic [7:0]  wrData;
  logic        rdStrobe;
  logic        idValid;
  logic [31:0] idBytes;
  logic [7:0]  driveStatusIn;
  logic        lastWasFormat;
  logic [7:0]  sectorsPerCylinder;
  logic [7:0]  endTrackSector;
  logic [7:0]  rdData;
  logic        resultReady;
  logic        cmdBusy;
  logic        standby;
  logic [7:0]  stepRateHeadUnload;
  logic [7:0]  headLoadNonDma;
  logic [7:0]  configByte;
  logic [7:0]  precompStartTrack;
  logic [7:0]  perpendicularByte;
  logic        lockValue;
  logic        idReadActive;
  int          mismatches;
  int          num_checks;

  // Rows: command, parameter, byte count, expected single result
  logic [31:0] rows [6] = '{32'h00000180, 32'hff000180, 32'h14000100,
                            32'h040502ad, 32'h040202aa, 32'h94000110};
  logic [7:0]  dumpExp [10] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'ha5,
                                8'h3b, 8'h12, 8'h8b, 8'h5a, 8'h07};
  logic [7:0]  idExp [7] = '{8'h00, 8'h00, 8'h00, 8'h0a, 8'h01, 8'h03, 8'h05};
  logic [7:0]  dumpRst [10] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00,
                                8'h00, 8'h09, 8'h00, 8'h20, 8'h00};

  floppy_cmd_interpreter floppy_cmd_interpreter_inst
  (
    .core_clk           (core_clk),
    .rst                (rst),
    .wrStrobe           (wrStrobe),
    .wrData             (wrData),
    .rdStrobe           (rdStrobe),
    .idValid            (idValid),
    .idBytes            (idBytes),
    .driveStatusIn      (driveStatusIn),
    .lastWasFormat      (lastWasFormat),
    .sectorsPerCylinder (sectorsPerCylinder),
    .endTrackSector     (endTrackSector),
    .rdData             (rdData),
    .resultReady        (resultReady),
    .cmdBusy            (cmdBusy),
    .standby            (standby),
    .stepRateHeadUnload (stepRateHeadUnload),
    .headLoadNonDma     (headLoadNonDma),
    .configByte         (configByte),
    .precompStartTrack  (precompStartTrack),
    .perpendicularByte  (perpendicularByte),
    .lockValue          (lockValue),
    .idReadActive       (idReadActive)
  );

  host_model host_model_inst
  (
    .core_clk,
    .rdData,
    .resultReady,
    .wrStrobe,
    .wrData,
    .rdStrobe
  );

  ////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Hang guard, far beyond the expected run
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    summarize();
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask

  // Bounded wait for the command phase to return
  task automatic waitIdle();
    int k = 0;
    @(negedge core_clk);
    while (cmdBusy !== 1'b0 && k < 3000)
    begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 3000)
      mismatches++;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    mismatches = 0;
    num_checks = 0;
    rst = 1'b1;
    idValid = 1'b0;
    idBytes = 32'h00000000;
    driveStatusIn = 8'ha8;
    lastWasFormat = 1'b1;  // Dump then reports the sector count
    sectorsPerCylinder = 8'h12;
    endTrackSector = 8'h09;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    chk(configByte, CONFIG_RESET);
    chk({7'h00, resultReady}, 8'h00);
    chk({7'h00, lockValue}, 8'h00);
    // Single-result commands from the table
    foreach (rows[i])
    begin
      host_model_inst.cmd({rows[i][31:16], 16'h0000}, int'(rows[i][15:8]));
      host_model_inst.get(1);
      chk(host_model_inst.res[0], rows[i][7:0]);
      chk({7'h00, standby}, {7'h00, rows[i][7:0] == INVALID_STATUS});
      waitIdle();
    end
    // Settings commands, results seen on the setting ports
    host_model_inst.cmd(32'h03a53b00, 3);
    waitIdle();
    host_model_inst.cmd(32'h13005a07, 4);
    waitIdle();
    host_model_inst.cmd(32'h128b0000, 2);
    waitIdle();
    chk(stepRateHeadUnload, 8'ha5);
    chk(headLoadNonDma, 8'h3b);
    chk(configByte, 8'h5a);
    chk(precompStartTrack, 8'h07);
    chk(perpendicularByte, 8'h8b);
    chk({7'h00, lockValue}, 8'h01);
    // Seek drive 1 to cylinder 5: busy while stepping, never a result
    host_model_inst.cmd(32'h0f010500, 3);
    repeat (3) @(negedge core_clk);
    chk({7'h00, cmdBusy}, 8'h01);
    waitIdle();
    chk({7'h00, resultReady}, 8'h00);
    host_model_inst.cmd(32'h08000000, 1);
    host_model_inst.get(2);
    chk(host_model_inst.res[0], SEEK_END_BASE | 8'h01);
    chk(host_model_inst.res[1], 8'h05);
    waitIdle();
    // Relative seek two cylinders inward, then dump all state
    host_model_inst.cmd(32'hcf010200, 3);
    waitIdle();
    host_model_inst.cmd(32'h0e000000, 1);
    host_model_inst.get(10);
    foreach (dumpExp[i])
      chk(host_model_inst.res[i], dumpExp[i]);
    waitIdle();
    // Read ID waits for the first good ID field
    host_model_inst.cmd(32'h4a000000, 2);
    repeat (3) @(negedge core_clk);
    chk({7'h00, idReadActive}, 8'h01);
    chk({7'h00, resultReady}, 8'h00);
    idBytes = 32'h0a010305;
    idValid = 1'b1;
    host_model_inst.get(7);
    idValid = 1'b0;
    for (int i = 0; i < 7; i++)
      chk(host_model_inst.res[i], idExp[i]);
    waitIdle();
    chk({7'h00, cmdBusy}, 8'h00);
    // Reset in mid-command drops the partial configure and all stored state
    host_model_inst.cmd(32'h13000000, 2);
    chk({7'h00, cmdBusy}, 8'h01);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    chk({7'h00, cmdBusy}, 8'h00);
    chk(configByte, CONFIG_RESET);
    chk(stepRateHeadUnload, TIMING_RESET);
    host_model_inst.cmd(32'h08000000, 1);
    host_model_inst.get(2);
    chk(host_model_inst.res[0], INVALID_STATUS);
    chk(host_model_inst.res[1], 8'h00);
    waitIdle();
    // Drive 2 out to 3, one step back, dump with end-of-track selected
    lastWasFormat = 1'b0;
    host_model_inst.cmd(32'h0f020300, 3);
    waitIdle();
    host_model_inst.cmd(32'h8f020100, 3);
    waitIdle();
    host_model_inst.cmd(32'h0e000000, 1);
    host_model_inst.get(10);
    foreach (dumpRst[i])
      chk(host_model_inst.res[i], dumpRst[i]);
    waitIdle();
    chk(8'(host_model_inst.timedOut), 8'h00);
    summarize();
  end
endmodule
